// ---- inc/rtts_pkg.sv ----
// rtts_pkg: register map, field layout, reset values and limits of the
// tamper timestamp capture block.
// assumes a 32-bit byte-addressed register port with one aligned word per register.
package rtts_pkg;

   // register port
   localparam int          REG_ADDR_W = 32;
   localparam int          REG_DATA_W = 32;

   // register byte addresses
   localparam logic [31:0] OFF_FIRST_TIMESTAMP = 32'hF804_8160;
   localparam logic [31:0] OFF_FIRST_UTC       = 32'hF804_8164;
   localparam logic [31:0] OFF_STATUS_SNAPSHOT = 32'hF804_8168;
   localparam logic [31:0] OFF_TAMPER_ENABLE   = 32'hF804_816C;
   localparam logic [31:0] OFF_INT_STATUS      = 32'hF804_8170;
   localparam logic [31:0] OFF_INT_MASK        = 32'hF804_8174;

   // tamper_first_timestamp fields
   localparam int          BACKUP_BIT   = 31;
   localparam int          COUNT_LSB    = 24;
   localparam int          COUNT_W      = 4;
   localparam logic [3:0]  COUNT_MAX    = 4'hF;
   localparam logic [3:0]  COUNT_ONE    = 4'h1;
   localparam logic [3:0]  COUNT_RESET  = 4'h0;

   // tamper_status_snapshot fields
   localparam int          SNAP_NONZERO_BIT = 31;

   // interrupt status / mask layout
   localparam int          INT_W         = 3;
   localparam int          INT_TAMPER    = 0;
   localparam int          INT_SATURATE  = 1;
   localparam int          INT_RO_WRITE  = 2;
   localparam logic [2:0]  INT_MASK_RESET = 3'h0;

   // reset values of the captured data
   localparam logic [31:0] UTC_RESET     = 32'h0000_0000;
   localparam logic        BACKUP_RESET  = 1'b0;

endpackage : rtts_pkg

// ---- sim/rtts_monitor.sv ----
// rtts_monitor: port assertions for the tamper capture block.
// assumes ce high while traffic is checked; bound to rtts_capture below.
`timescale 1ns/1ps
`default_nettype none
module rtts_monitor #(
   parameter int          NUM_TAMPER   = 4,
   parameter logic [31:0] ENABLE_RESET = 32'h0000_000F
) (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  ce,
   input wire logic [NUM_TAMPER-1:0] tamper_pin,
   input wire logic                  backup_mode_pin,
   input wire logic [31:0]           utc_seconds,
   input wire logic [31:0]           reg_addr,
   input wire logic [31:0]           reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [31:0]           reg_rdata,
   input wire logic                  irq,
   input wire logic                  tamper_valid
);
   logic [31:0]           en;
   logic [NUM_TAMPER-1:0] p1, p2, p3, p4;
   logic                  rd_ts, rd_snap, quiet;
   assign rd_ts = reg_rd && reg_addr == rtts_pkg::OFF_FIRST_TIMESTAMP;
   assign rd_snap = reg_rd && reg_addr == rtts_pkg::OFF_STATUS_SNAPSHOT;
   // no pin edge still on its way through the synchroniser
   assign quiet = tamper_pin == p1 && p1 == p2 && p2 == p3;
   always_ff @(posedge clk) begin
      if (rst) begin
         en <= ENABLE_RESET;
      end else if (ce && reg_wr && reg_addr == rtts_pkg::OFF_TAMPER_ENABLE) begin
         en <= reg_wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (ce) begin
         p1 <= tamper_pin;
         p2 <= p1;
         p3 <= p2;
         p4 <= p3;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);
   property p_ts_layout;
      $past(rd_ts) |-> reg_rdata[30:0] == {3'h0, reg_rdata[27:24], 24'h0}
         && (reg_rdata[27:24] != 4'h0) == $past(tamper_valid);
   endproperty
   a_ts_layout: assert property (p_ts_layout) else $error("timestamp layout wrong");
   property p_snap_flag;
      $past(rd_snap) |-> reg_rdata[31] == $past(tamper_valid);
   endproperty
   a_snap_flag: assert property (p_snap_flag) else $error("snapshot flag wrong");
   property p_read_clear;
      rd_snap && quiet |=> !tamper_valid;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("snapshot read kept count");
   property p_fall_cause;
      $fell(tamper_valid) |-> $past(rd_snap);
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("count cleared without read");
   property p_rise_cause;
      $rose(tamper_valid) |-> (p3 & ~p4 & en[NUM_TAMPER-1:0]) != '0;
   endproperty
   a_rise_cause: assert property (p_rise_cause) else $error("count rose without event");
   property p_event;
      (tamper_pin & ~p1 & en[NUM_TAMPER-1:0]) != '0 |-> ##3 tamper_valid;
   endproperty
   a_event: assert property (p_event) else $error("event not counted");
   property p_backup_clear;
      $past(rd_ts) && !$past(tamper_valid) |-> !reg_rdata[31];
   endproperty
   a_backup_clear: assert property (p_backup_clear) else $error("backup flag left set");
   property p_ro_write;
      reg_wr && reg_addr == rtts_pkg::OFF_FIRST_TIMESTAMP && quiet |=> $stable(tamper_valid);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("write altered timestamp");
endmodule : rtts_monitor
bind rtts_capture rtts_monitor #(.NUM_TAMPER(NUM_TAMPER), .ENABLE_RESET(ENABLE_RESET)) mon_u (
   .clk(clk), .rst(rst), .ce(ce), .tamper_pin(tamper_pin), .backup_mode_pin(backup_mode_pin),
   .utc_seconds(utc_seconds), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tamper_valid(tamper_valid));
`default_nettype wire

// ---- sim/test_rtts_capture.sv ----
// test_rtts_capture: random and corner-case bench for the tamper capture block.
// assumes default parameters (four pins, all enabled) and ce tied high.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", nm, e, s); end end
module test_rtts_capture;
   localparam logic [31:0] A_TS = rtts_pkg::OFF_FIRST_TIMESTAMP;
   localparam logic [31:0] A_SS = rtts_pkg::OFF_STATUS_SNAPSHOT;
   localparam logic [31:0] A_IS = rtts_pkg::OFF_INT_STATUS;
   localparam logic [31:0] A_EN = rtts_pkg::OFF_TAMPER_ENABLE;
   logic        clk, rst, bk, wr_s, rd_s, irq, tv;
   logic [3:0]  pin;
   logic [31:0] utc, addr, wdata, rdata, d, v1;
   int          n_mismatch, n_compared, seed, k;
   rtts_capture dut_u (.clk(clk), .rst(rst), .ce(1'b1), .tamper_pin(pin), .backup_mode_pin(bk),
      .utc_seconds(utc), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
      .reg_rdata(rdata), .irq(irq), .tamper_valid(tv));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] ts_exp(input int c, input logic b);
      return {b, 3'h0, (c > 15) ? 4'hF : 4'(c), 24'h0};
   endfunction : ts_exp
   task automatic wr(input logic [31:0] a, input logic [31:0] w);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= w;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 q = rdata;
   endtask : rd
   // backup level and time settle one cycle before the pin rises
   task automatic ev(input logic [3:0] p, input logic b, input logic [31:0] u);
      @(posedge clk);
      bk <= b;
      utc <= u;
      @(posedge clk);
      pin <= p;
      repeat (4) @(posedge clk);
      pin <= 4'h0;
      repeat (4) @(posedge clk);
   endtask : ev
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end
   initial begin
      {rst, bk, wr_s, rd_s, pin, utc, addr, wdata} = '0;
      rst = 1'b1;
      n_mismatch = 0;
      n_compared = 0;
      seed = $urandom(27);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(A_TS, d);
      `CHK("timestamp", 32'h0, d)
      rd(A_EN, d);
      `CHK("enable", 32'hF, d)
      rd(32'hF804_8180, d);
      `CHK("unmapped", 32'h0, d)
      $display("test reset done");
      v1 = $urandom;
      ev(4'h2, 1'b1, v1);
      ev(4'h4, 1'b0, $urandom);
      rd(rtts_pkg::OFF_FIRST_UTC, d);
      `CHK("first utc", v1, d)
      rd(A_TS, d);
      `CHK("timestamp", ts_exp(2, 1'b1), d)
      `CHK("irq masked", 1'b0, irq)
      wr(rtts_pkg::OFF_INT_MASK, 32'h4);
      wr(A_TS, $urandom);
      rd(A_TS, d);
      `CHK("ro write", ts_exp(2, 1'b1), d)
      `CHK("irq", 1'b1, irq)
      rd(A_IS, d);
      `CHK("int status", 32'h5, d)
      @(posedge clk);
      #1 `CHK("irq cleared", 1'b0, irq)
      `CHK("rdata idle", 32'h0, rdata)
      $display("test capture done");
      rd(A_SS, d);
      `CHK("snapshot", 32'h8000_0602, d)
      rd(A_TS, d);
      `CHK("cleared", 32'h0, d)
      `CHK("valid", 1'b0, tv)
      $display("test clear done");
      k = 16 + $urandom_range(4);
      for (int i = 0; i < k; i++) begin
         ev(4'(1 + $urandom_range(14)), (i == 0) ? 1'b0 : 1'($urandom), $urandom);
         rd(A_TS, d);
         `CHK("count", ts_exp(i + 1, 1'b0), d)
      end
      rd(A_IS, d);
      `CHK("saturated", 32'h3, d)
      rd(A_SS, d);
      `CHK("snap flag", 1'b1, d[31])
      `CHK("valid", 1'b0, tv)
      $display("test saturate done");
      wr(A_EN, 32'hE);
      ev(4'h1, 1'b0, $urandom);
      `CHK("disabled pin", 1'b0, tv)
      ev(4'h8, 1'b0, $urandom);
      `CHK("enabled pin", 1'b1, tv)
      $display("test enable done");
      stop_test();
   end
endmodule : test_rtts_capture
`default_nettype wire

// ---- verilog/rtts_capture.sv ----
// rtts_capture: tamper timestamp capture for a real-time clock in universal
// time format, with event counter, backup-mode flag, register port and irq.
// assumes utc_seconds comes from the clock's own time base on clk; tamper
// pins and the backup-mode level are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - first tamper event after a clear freezes the time; later events keep it
// - every detected tamper event adds one to the event counter while it is below 15
// - the event counter stops at 15 and never wraps
// - reading the status snapshot register clears the event counter
// - counter nonzero means a valid capture exists since the last clear
// - backup flag captures 1 if in backup mode at the first event after a clear, else 0
// - reading the status snapshot register also clears the backup flag
module rtts_capture #(
   parameter int          NUM_TAMPER   = 4,
   parameter logic [31:0] ENABLE_RESET = 32'h0000_000F
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic [NUM_TAMPER-1:0] tamper_pin,
   input  wire logic                  backup_mode_pin,
   input  wire logic [31:0]           utc_seconds,
   input  wire logic [31:0]           reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   output logic                       irq,
   output logic                       tamper_valid
);

   // synchronised inputs
   logic [NUM_TAMPER:0]   sync_q;
   logic [NUM_TAMPER-1:0] tamper_lvl;
   logic                  backup_lvl;
   logic [NUM_TAMPER-1:0] tamper_prev;
   logic [NUM_TAMPER-1:0] tamper_rise;
   logic                  tamper_event;

   // captured state
   logic [3:0]            tamper_event_count;
   logic                  backup_flag;
   logic [31:0]           first_utc;
   logic [NUM_TAMPER-1:0] first_source;
   logic [NUM_TAMPER-1:0] seen_source;

   // software-controlled state
   logic [NUM_TAMPER-1:0] tamper_enable;
   logic [2:0]            int_status;
   logic [2:0]            int_mask;

   // decoded accesses
   logic                  rd_snapshot;
   logic                  rd_int_status;
   logic                  wr_enable;
   logic                  wr_mask;
   logic                  wr_read_only;
   logic                  count_zero;
   logic                  count_full;
   logic                  hits_max;
   logic [2:0]            int_set;
   logic [31:0]           next_rdata;

   rtts_sync #(
      .WIDTH (NUM_TAMPER + 1)
   ) u_sync (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .din  ({backup_mode_pin, tamper_pin}),
      .dout (sync_q)
   );

   assign tamper_lvl = sync_q[NUM_TAMPER-1:0];
   assign backup_lvl = sync_q[NUM_TAMPER];

   // --------------------------------------------------------------------
   // tamper detection: rising edge of each enabled, synchronised pin
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tamper_prev <= '0;
      end else if (ce) begin
         tamper_prev <= tamper_lvl;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_TAMPER; gi++) begin : g_edge
         assign tamper_rise[gi] = tamper_lvl[gi] & ~tamper_prev[gi] & tamper_enable[gi];
      end
   endgenerate

   assign tamper_event = |tamper_rise;

   // --------------------------------------------------------------------
   // register port decode
   // --------------------------------------------------------------------
   assign rd_snapshot   = reg_rd && (reg_addr == rtts_pkg::OFF_STATUS_SNAPSHOT);
   assign rd_int_status = reg_rd && (reg_addr == rtts_pkg::OFF_INT_STATUS);
   assign wr_enable     = reg_wr && (reg_addr == rtts_pkg::OFF_TAMPER_ENABLE);
   assign wr_mask       = reg_wr && (reg_addr == rtts_pkg::OFF_INT_MASK);

   // writes aimed at the capture registers are dropped and only flagged
   assign wr_read_only  = reg_wr && ((reg_addr == rtts_pkg::OFF_FIRST_TIMESTAMP) ||
                                     (reg_addr == rtts_pkg::OFF_FIRST_UTC) ||
                                     (reg_addr == rtts_pkg::OFF_STATUS_SNAPSHOT));

   assign count_zero = (tamper_event_count == rtts_pkg::COUNT_RESET);
   assign count_full = (tamper_event_count == rtts_pkg::COUNT_MAX);
   assign hits_max   = tamper_event && (tamper_event_count == rtts_pkg::COUNT_MAX - rtts_pkg::COUNT_ONE);

   // --------------------------------------------------------------------
   // event counter
   // a snapshot read and an event in the same cycle leave a count of one:
   // the event is never lost to the clear
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tamper_event_count <= rtts_pkg::COUNT_RESET;
      end else if (ce) begin
         if (rd_snapshot && tamper_event) begin
            tamper_event_count <= rtts_pkg::COUNT_ONE;
         end else if (rd_snapshot) begin
            tamper_event_count <= rtts_pkg::COUNT_RESET;
         end else if (tamper_event && !count_full) begin
            tamper_event_count <= tamper_event_count + rtts_pkg::COUNT_ONE;
         end
      end
   end

   // --------------------------------------------------------------------
   // backup-mode flag: caught with the first event, cleared by snapshot read
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         backup_flag <= rtts_pkg::BACKUP_RESET;
      end else if (ce) begin
         if (tamper_event && (count_zero || rd_snapshot)) begin
            backup_flag <= backup_lvl;
         end else if (rd_snapshot) begin
            backup_flag <= rtts_pkg::BACKUP_RESET;
         end
      end
   end

   // --------------------------------------------------------------------
   // first-event time and source: loaded only while no event is recorded or in a snapshot read cycle
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         first_utc    <= rtts_pkg::UTC_RESET;
         first_source <= '0;
      end else if (ce) begin
         if (tamper_event && (count_zero || rd_snapshot)) begin
            first_utc    <= utc_seconds;
            first_source <= tamper_rise;
         end
      end
   end

   // every source that fired since the last snapshot read
   always_ff @(posedge clk) begin
      if (rst) begin
         seen_source <= '0;
      end else if (ce) begin
         if (rd_snapshot) begin
            seen_source <= tamper_rise;
         end else begin
            seen_source <= seen_source | tamper_rise;
         end
      end
   end

   // --------------------------------------------------------------------
   // software control: per-pin enable and interrupt mask
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tamper_enable <= ENABLE_RESET[NUM_TAMPER-1:0];
      end else if (ce && wr_enable) begin
         tamper_enable <= reg_wdata[NUM_TAMPER-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         int_mask <= rtts_pkg::INT_MASK_RESET;
      end else if (ce && wr_mask) begin
         int_mask <= reg_wdata[rtts_pkg::INT_W-1:0];
      end
   end

   // --------------------------------------------------------------------
   // interrupt status: sticky, cleared by its own read, set beats clear
   // --------------------------------------------------------------------
   always_comb begin
      int_set                        = '0;
      int_set[rtts_pkg::INT_TAMPER]   = tamper_event;
      int_set[rtts_pkg::INT_SATURATE] = hits_max && !rd_snapshot;
      int_set[rtts_pkg::INT_RO_WRITE] = wr_read_only;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         int_status <= '0;
      end else if (ce) begin
         if (rd_int_status) begin
            int_status <= int_set;
         end else begin
            int_status <= int_status | int_set;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |((rd_int_status ? int_set : (int_status | int_set)) & int_mask);
      end
   end

   // a nonzero counter is the sign that the captured values are valid
   always_ff @(posedge clk) begin
      if (rst) begin
         tamper_valid <= 1'b0;
      end else if (ce) begin
         tamper_valid <= (rd_snapshot ? tamper_event : (tamper_event || !count_zero));
      end
   end

   // --------------------------------------------------------------------
   // read data: shows the state before the read's own side effects
   // --------------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      case (reg_addr)
         rtts_pkg::OFF_FIRST_TIMESTAMP: begin
            next_rdata[rtts_pkg::BACKUP_BIT] = backup_flag;
            next_rdata[rtts_pkg::COUNT_LSB +: rtts_pkg::COUNT_W] = tamper_event_count;
         end
         rtts_pkg::OFF_FIRST_UTC: begin
            next_rdata = first_utc;
         end
         rtts_pkg::OFF_STATUS_SNAPSHOT: begin
            next_rdata[rtts_pkg::SNAP_NONZERO_BIT] = !count_zero;
            next_rdata[NUM_TAMPER-1:0] = first_source;
            next_rdata[8 +: NUM_TAMPER] = seen_source;
         end
         rtts_pkg::OFF_TAMPER_ENABLE: begin
            next_rdata[NUM_TAMPER-1:0] = tamper_enable;
         end
         rtts_pkg::OFF_INT_STATUS: begin
            next_rdata[rtts_pkg::INT_W-1:0] = int_status;
         end
         rtts_pkg::OFF_INT_MASK: begin
            next_rdata[rtts_pkg::INT_W-1:0] = int_mask;
         end
         default: begin
            next_rdata = '0;
         end
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? next_rdata : '0;
      end
   end

endmodule : rtts_capture

`default_nettype wire

// ---- verilog/rtts_sync.sv ----
// rtts_sync: two-flop synchroniser for a vector of asynchronous levels.
// assumes each bit is an independent level that stays stable for several clocks.
`timescale 1ns/1ps
`default_nettype none

module rtts_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else if (ce) begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : rtts_sync

`default_nettype wire
